// [host_model.sv]
// Host model: writes the tone-force register bit and drives the tone gate pin
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input  wire logic clock,           // System clock
  input  wire logic req_force,       // Wanted tone-force bit
  input  wire logic req_gate,        // Wanted gate level
  input  wire logic burst,           // Gate pin carries bursts
  output logic      tone_force_bit,  // Register bit
  output logic      tone_gate_pin    // Modulation pin
);
  logic force_q;
  logic gate_q;
  logic burst_q;

  initial begin
    tone_force_bit = 1'b0;
    tone_gate_pin  = 1'b0;
  end

  // Requests are taken on the rising edge so the bench and model never race
  always @(posedge clock) begin
    force_q <= req_force;
    gate_q  <= req_gate;
    burst_q <= burst;
  end

  // Bursts hold the gate low until the force bit is seen cleared
  always @(negedge clock) begin
    if (burst_q) begin
      tone_force_bit <= 1'b0;
      tone_gate_pin  <= tone_force_bit ? 1'b0 : gate_q;
    end else begin
      tone_force_bit <= force_q;
      tone_gate_pin  <= gate_q;
    end
  end
endmodule : host_model

`default_nettype wire

// [lnb_defines.svh]
// Timing counts, reset values and address constants of the supply and tone controller
`ifndef LNB_DEFINES_SVH
`define LNB_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and oscillator
// ----------------------------------------------------------------------------
`define CLK_HZ               100000000
`define TONE_HZ              22000
`define OSC_PER_TONE         10
// One tick per half period of the converter oscillator, rounded down
`define TICK_DIV             (`CLK_HZ / (2 * `TONE_HZ * `OSC_PER_TONE))
`define TICK_CNT_W           8
// Ticks per half tone period: one tone period is OSC_PER_TONE oscillator periods
`define TONE_HALF_TICKS      `OSC_PER_TONE
`define TONE_CNT_W           4

// ----------------------------------------------------------------------------
// Soft-start
// ----------------------------------------------------------------------------
`define SOFTSTART_OSC_CYCLES 1024
`define SOFTSTART_W          10

// ----------------------------------------------------------------------------
// Serial bus address choice and readback layout
// ----------------------------------------------------------------------------
`define BUS_ADDR_W           7
`define BUS_ADDR_LOW         7'h08
`define BUS_ADDR_HIGH        7'h09
// A pin held through reset reaches the filtered level only after four edges
`define ADDR_SETTLE_CYCLES   3'h4
`define RB_OVERTEMP          0
`define RB_OVERLOAD          1
`define RB_ENABLE            2
`define RB_VOLTAGE_SELECT_BIT              3
`define RB_CABLE             4
`define RB_TONE_FORCE        5
`define READBACK_W           8

`endif

// [lnb_pkg.sv]
// Types shared by the supply and tone controller
package lnb_pkg;

  // --------------------------------------------------------------------------
  // Converter sequencing, Gray coded along off -> soft-start -> run
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF   = 2'h0,
    ST_SOFT  = 2'h1,
    ST_RUN   = 2'h3,
    ST_HOT   = 2'h2
  } conv_state_t;

  // --------------------------------------------------------------------------
  // Output voltage setting
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VOUT_13V = 2'h0,
    VOUT_14V = 2'h1,
    VOUT_18V = 2'h2,
    VOUT_19V = 2'h3
  } vout_t;

endpackage : lnb_pkg

// [lnb_supply_tone_control.sv]
// Digital control of the antenna supply regulator: tone, converter clock, sequencing
// Overview of operation
// - Tone-force bit high keeps the tone on continuously, gate pin ignored.
// - With tone-force low, tone-gate pin high turns tone on, low turns it off.
// - Converter clock comes from the tone oscillator at ten times tone rate.
// - Tone frequency is fixed at 22kHz, nothing adjusts it.
// - Control functions come from host-written register bits and the tone gate, high-voltage select and address pins.
// - Readback returns written bits, with two live diagnostic status bits.
// - Cable compensation comes only from its register bit; voltage-select is the register bit OR the pin.
// - High-voltage select pin high forces the 18V setting.
// - Gate output is held low while undervoltage lockout is active.
// - Converter and regulator are disabled during undervoltage lockout.
// - Address pin level picks one of two serial bus addresses.
// - Tone starts and stops promptly after each gate pin transition.
// - Voltage-select picks 13V or 18V; cable compensation adds 1V.
// - Enable low means shutdown; enable high activates the regulator.
// - Overtemperature stops converter, sets status bit; clears and resumes when cool.
// - Start-up ramps error amplifier over 1024 oscillator cycles.
`timescale 1ns/10ps
`default_nettype none
`include "lnb_defines.svh"

module lnb_supply_tone_control #(
  parameter int SOFTSTART_CYCLES = `SOFTSTART_OSC_CYCLES
) (
  input  wire logic                   clock,                       // 100 MHz system clock
  input  wire logic                   reset_n,                     // Synchronous reset
  input  wire logic                   tone_force_bit,              // Register: continuous tone
  input  wire logic                   voltage_select_bit,          // Register: 18V when high
  input  wire logic                   cable_compensation_bit,      // Register: add 1V
  input  wire logic                   enable_bit,                  // Register: regulator on
  input  wire logic                   tone_gate_pin,               // Pin: tone modulation
  input  wire logic                   high_voltage_select_pin,     // Pin: force 18V
  input  wire logic                   address_pin,                 // Pin: bus address choice
  input  wire logic                   undervoltage_lockout,        // Supply below threshold
  input  wire logic                   overtemp_detect,             // Die too hot
  input  wire logic                   overload_detect,             // Output overload seen
  output logic                        gate_drive,                  // Power switch gate
  output logic                        regulator_enable,            // Linear regulator on
  output logic                        tone_out,                    // Tone onto the output
  output lnb_pkg::vout_t              vout_setting,                // Selected output voltage
  output logic [`SOFTSTART_W-1:0]     comp_ramp,                   // Error amplifier ramp
  output logic                        overtemperature_status_bit,  // Live status
  output logic                        overload_status_bit,         // Live status
  output logic [`READBACK_W-1:0]      readback_data,               // Register readback
  output logic [`BUS_ADDR_W-1:0]      bus_address                  // Address responded to
);
  import lnb_pkg::*;

  localparam int SYNC_W = 6;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  initial begin
    if (SOFTSTART_CYCLES < 1 || SOFTSTART_CYCLES > (1 << `SOFTSTART_W)) begin
      $error("lnb_supply_tone_control: SOFTSTART_CYCLES out of range");
    end
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    conv_state_t              state;
    logic [`SOFTSTART_W-1:0]  ss_cnt;
    logic [`SOFTSTART_W-1:0]  ramp;
    logic                     tone_en;
    logic                     tone;
    logic                     gate;
    logic                     reg_en;
    vout_t                    vout;
    logic                     ot_flag;
    logic                     ol_flag;
    logic [`READBACK_W-1:0]   rb;
    logic [2:0]               addr_wait;
    logic                     addr_taken;
    logic [`BUS_ADDR_W-1:0]   addr;
  } ctl_state_t;

  ctl_state_t cur_ff;
  ctl_state_t nxt_cur;

  logic [SYNC_W-1:0] pins_sync;
  logic              gate_pin_s;
  logic              hv_pin_s;
  logic              addr_pin_s;
  logic              undervoltage_lockout_s;
  logic              ot_s;
  logic              ol_s;
  logic              osc_period;
  logic              conv_phase;
  logic              tone_phase;
  logic              high_volt;

  // --------------------------------------------------------------------------
  // Pin synchronisers and oscillator
  // --------------------------------------------------------------------------
  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pin_in  ({overload_detect, overtemp_detect, undervoltage_lockout,
               address_pin, high_voltage_select_pin, tone_gate_pin}),
    .pin_out (pins_sync)
  );

  assign gate_pin_s = pins_sync[0];
  assign hv_pin_s   = pins_sync[1];
  assign addr_pin_s = pins_sync[2];
  assign undervoltage_lockout_s     = pins_sync[3];
  assign ot_s       = pins_sync[4];
  assign ol_s       = pins_sync[5];

  osc_divider u_osc (
    .clock      (clock),
    .reset_n    (reset_n),
    .osc_period (osc_period),
    .conv_phase (conv_phase),
    .tone_phase (tone_phase)
  );

  // Pin is an override only: with the pin low the register bit alone decides
  assign high_volt = voltage_select_bit | hv_pin_s;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;

    // Sequencing; lockout and a low enable win over everything, then temperature
    unique case (cur_ff.state)
      ST_OFF: begin
        if (!undervoltage_lockout_s && enable_bit && !ot_s) begin
          nxt_cur.state  = ST_SOFT;
          nxt_cur.ss_cnt = '0;
          nxt_cur.ramp   = '0;
        end
      end
      ST_SOFT: begin
        if (osc_period) begin
          nxt_cur.ss_cnt = cur_ff.ss_cnt + `SOFTSTART_W'(1);
          nxt_cur.ramp   = cur_ff.ss_cnt;
          if (cur_ff.ss_cnt == `SOFTSTART_W'(SOFTSTART_CYCLES - 1)) begin
            nxt_cur.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        nxt_cur.ramp = '1;
      end
      ST_HOT: begin
        if (!ot_s) begin
          nxt_cur.state  = ST_SOFT;
          nxt_cur.ss_cnt = '0;
          nxt_cur.ramp   = '0;
        end
      end
    endcase
    if (cur_ff.state != ST_OFF && cur_ff.state != ST_HOT && ot_s) begin
      nxt_cur.state = ST_HOT;
      nxt_cur.ramp  = '0;
    end
    if (undervoltage_lockout_s || !enable_bit) begin
      nxt_cur.state = ST_OFF;
      nxt_cur.ramp  = '0;
    end

    // Regulator and gate follow the new state so no stale pulse leaks out
    nxt_cur.reg_en = (nxt_cur.state == ST_SOFT) || (nxt_cur.state == ST_RUN);
    nxt_cur.gate   = nxt_cur.reg_en && conv_phase && !undervoltage_lockout_s;

    // Tone: force bit overrides the pin; one cycle after the filtered pin edge
    nxt_cur.tone_en = tone_force_bit | gate_pin_s;
    nxt_cur.tone    = nxt_cur.tone_en && tone_phase;

    // Voltage setting
    unique case ({high_volt, cable_compensation_bit})
      2'b00:   nxt_cur.vout = VOUT_13V;
      2'b01:   nxt_cur.vout = VOUT_14V;
      2'b10:   nxt_cur.vout = VOUT_18V;
      2'b11:   nxt_cur.vout = VOUT_19V;
    endcase

    // Status flags are live levels, not sticky
    nxt_cur.ot_flag = ot_s;
    nxt_cur.ol_flag = ol_s;

    // Readback of written bits plus two diagnostic bits
    nxt_cur.rb                 = '0;
    nxt_cur.rb[`RB_OVERTEMP]   = ot_s;
    nxt_cur.rb[`RB_OVERLOAD]   = ol_s;
    nxt_cur.rb[`RB_ENABLE]     = enable_bit;
    nxt_cur.rb[`RB_VOLTAGE_SELECT_BIT]       = voltage_select_bit;
    nxt_cur.rb[`RB_CABLE]      = cable_compensation_bit;
    nxt_cur.rb[`RB_TONE_FORCE] = tone_force_bit;

    // Address is taken once, after the synchroniser has settled from reset
    if (!cur_ff.addr_taken) begin
      if (cur_ff.addr_wait == `ADDR_SETTLE_CYCLES) begin
        nxt_cur.addr_taken = 1'b1;
        nxt_cur.addr       = addr_pin_s ? `BUS_ADDR_HIGH : `BUS_ADDR_LOW;
      end else begin
        nxt_cur.addr_wait  = cur_ff.addr_wait + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur_ff      <= '0;
      cur_ff.addr <= `BUS_ADDR_LOW;
    end else begin
      cur_ff      <= nxt_cur;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign gate_drive                 = cur_ff.gate;
  assign regulator_enable           = cur_ff.reg_en;
  assign tone_out                   = cur_ff.tone;
  assign vout_setting               = cur_ff.vout;
  assign comp_ramp                  = cur_ff.ramp;
  assign overtemperature_status_bit = cur_ff.ot_flag;
  assign overload_status_bit        = cur_ff.ol_flag;
  assign readback_data              = cur_ff.rb;
  assign bus_address                = cur_ff.addr;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_tone_force_on: assert property (tone_force_bit |=> cur_ff.tone_en)
    else $error("tone not enabled while forced");

  a_tone_gate_follow: assert property (
    !tone_force_bit |=> cur_ff.tone_en == $past(gate_pin_s))
    else $error("tone enable does not follow gate pin");

  a_tone_out_gated: assert property (
    tone_out |-> ($past(tone_force_bit) || $past(gate_pin_s)) && $past(tone_phase))
    else $error("tone present while disabled");

  a_tone_stop_fast: assert property (
    (!tone_force_bit && !gate_pin_s) |=> !tone_out)
    else $error("tone did not stop after gate fell");

  a_gate_undervoltage_lockout: assert property (undervoltage_lockout_s |=> !gate_drive)
    else $error("gate driven during undervoltage lockout");

  a_undervoltage_lockout_off: assert property (
    undervoltage_lockout_s |=> (cur_ff.state == ST_OFF) && !regulator_enable)
    else $error("converter active during undervoltage lockout");

  a_hv_select: assert property (
    hv_pin_s |=> (vout_setting == VOUT_18V) || (vout_setting == VOUT_19V))
    else $error("high voltage pin did not force 18V");

  a_cable_raise: assert property (
    (cable_compensation_bit && !high_volt) |=> vout_setting == VOUT_14V)
    else $error("cable compensation did not add 1V");

  a_enable_off: assert property (!enable_bit |=> !regulator_enable)
    else $error("regulator active while disabled");

  a_overtemp_flag: assert property (
    ot_s |=> overtemperature_status_bit && !gate_drive)
    else $error("overtemperature not flagged or converter running");

  a_softstart_end: assert property (
    (cur_ff.state == ST_SOFT && osc_period && !undervoltage_lockout_s && enable_bit && !ot_s &&
     cur_ff.ss_cnt == `SOFTSTART_W'(SOFTSTART_CYCLES - 1)) |=> cur_ff.state == ST_RUN)
    else $error("soft-start did not end after its cycle count");

  // Gate is registered, so it lines up with the previous converter phase
  a_gate_only_run: assert property (
    gate_drive |-> regulator_enable && $past(conv_phase))
    else $error("gate pulse outside converter clock");

  a_tone_conv_lock: assert property ($changed(tone_phase) |-> $changed(conv_phase))
    else $error("tone edge not aligned to converter clock");

  a_addr_hold: assert property (cur_ff.addr_taken |=> $stable(bus_address))
    else $error("bus address changed after capture");

  a_status_readback: assert property (
    readback_data[`RB_OVERTEMP] == overtemperature_status_bit &&
    readback_data[`RB_OVERLOAD] == overload_status_bit)
    else $error("readback status bits disagree with live status");

  c_tone_burst:    cover property (!tone_force_bit ##1 $rose(cur_ff.tone_en) ##[1:1000] tone_out);
  c_softstart_end: cover property ($rose(cur_ff.state == ST_RUN));
  c_overtemp_rec:  cover property (cur_ff.state == ST_HOT ##[1:50] cur_ff.state == ST_SOFT);
  c_lockout_off:   cover property ($rose(undervoltage_lockout_s) ##1 cur_ff.state == ST_OFF);
  c_addr_high:     cover property (bus_address == `BUS_ADDR_HIGH);

endmodule : lnb_supply_tone_control

`default_nettype wire

// [lnb_supply_tone_control_tb.sv]
// Self-checking bench of the supply and tone controller
`timescale 1ns/10ps
`default_nettype none

module lnb_supply_tone_control_tb;
  import lnb_pkg::*;
  localparam int TICK = 100000000 / (2 * 22000 * 10);
  localparam int HALF_TONE = TICK * 10;
  localparam int SS = 4;
  logic clock, reset_n, req_force, req_gate, burst, force_bit, gate_pin;
  logic sel, cable, en, hv, addr, uv, hot, ol;
  logic gate_drive, reg_en, tone_out, ot_st, ol_st;
  vout_t vout;
  logic [9:0] ramp;
  logic [7:0] rb;
  logic [6:0] bus_addr;
  int fails, checked, seed, n;
  bit hi;

  host_model i_host (.clock(clock), .req_force(req_force), .req_gate(req_gate),
    .burst(burst), .tone_force_bit(force_bit), .tone_gate_pin(gate_pin));

  lnb_supply_tone_control #(.SOFTSTART_CYCLES(SS)) i_dut (.clock(clock), .reset_n(reset_n),
    .tone_force_bit(force_bit), .voltage_select_bit(sel), .cable_compensation_bit(cable),
    .enable_bit(en), .tone_gate_pin(gate_pin), .high_voltage_select_pin(hv),
    .address_pin(addr), .undervoltage_lockout(uv), .overtemp_detect(hot),
    .overload_detect(ol), .gate_drive(gate_drive), .regulator_enable(reg_en),
    .tone_out(tone_out), .vout_setting(vout), .comp_ramp(ramp),
    .overtemperature_status_bit(ot_st), .overload_status_bit(ol_st),
    .readback_data(rb), .bus_address(bus_addr));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      fails++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  function automatic logic sig(input bit g);
    return g ? gate_drive : tone_out;
  endfunction : sig

  // 13V, 14V, 18V, 19V: high-voltage request is the bit OR the pin
  function automatic vout_t exp_vout(input bit s, input bit c, input bit h);
    return vout_t'({s | h, c});
  endfunction : exp_vout

  // Skips a partial high phase so only a whole one is measured
  task automatic hi_len(input bit g, output int len);
    int k;
    k = 0;
    len = 0;
    while (sig(g) !== 1'b0 && k < 6000) begin
      cyc(1);
      k++;
    end
    while (sig(g) !== 1'b1 && k < 12000) begin
      cyc(1);
      k++;
    end
    while (sig(g) === 1'b1 && len < 6000) begin
      cyc(1);
      len++;
    end
  endtask : hi_len

  task automatic any_hi(input bit g, input int k, output bit seen);
    seen = 1'b0;
    repeat (k) begin
      cyc(1);
      if (sig(g) !== 1'b0)
        seen = 1'b1;
    end
  endtask : any_hi

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    // Worst case path is about 50k cycles
    #800000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    seed = 20015;
    fails = 0;
    checked = 0;
    {reset_n, req_force, req_gate, burst, sel, cable, en, hv, addr, uv, hot, ol} = '0;
    cyc(4);
    chk(tone_out === 1'b0 && gate_drive === 1'b0, "reset outputs");
    reset_n = 1'b1;
    cyc(8);
    chk(bus_addr === 7'h08, "address low");
    req_force = 1'b1;
    hi_len(0, n);
    chk(n == HALF_TONE, "forced tone");
    $display("end forced tone");
    burst = 1'b1;
    cyc(4);
    any_hi(0, 3000, hi);
    chk(!hi, "tone with gate low");
    for (int i = 0; i < 4; i++) begin
      req_gate = 1'b1;
      cyc(6);
      hi_len(0, n);
      chk(n == HALF_TONE, "burst tone");
      n = 0;
      while (tone_out !== 1'b1 && n < 6000) begin
        cyc(1);
        n++;
      end
      // Gate drops inside a high phase, so a slow stop would leave the tone high
      req_gate = 1'b0;
      cyc(7);
      any_hi(0, 500, hi);
      chk(!hi && n < 6000, "burst stop");
    end
    $display("end bursts");
    for (int i = 0; i < 12; i++) begin
      {sel, cable, hv} = (i == 0) ? 3'b001 : 3'($random(seed));
      cyc(8);
      chk(vout === exp_vout(sel, cable, hv), "voltage");
    end
    $display("end voltage");
    burst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {req_force, sel, cable, en, ol} = 5'($random(seed));
      cyc(8);
      chk(rb === {2'h0, req_force, cable, sel, en, ol, 1'b0} && ol_st === ol, "readback");
    end
    $display("end readback");
    {en, ol} = 2'h0;
    cyc(6);
    chk(reg_en === 1'b0 && gate_drive === 1'b0, "shutdown");
    en = 1'b1;
    cyc(3);
    chk(reg_en === 1'b1 && ramp !== 10'h3FF, "soft start");
    cyc(3 * 2 * TICK - 12);
    chk(ramp !== 10'h3FF, "ramp early");
    cyc(2 * 2 * TICK);
    chk(ramp === 10'h3FF, "ramp end");
    hi_len(1, n);
    chk(n == TICK, "converter clock");
    $display("end start-up");
    uv = 1'b1;
    cyc(6);
    any_hi(1, 1000, hi);
    chk(!hi && reg_en === 1'b0, "lockout");
    uv = 1'b0;
    cyc(6);
    chk(reg_en === 1'b1 && ramp !== 10'h3FF, "restart");
    hot = 1'b1;
    cyc(6);
    any_hi(1, 600, hi);
    chk(!hi && reg_en === 1'b0 && ot_st === 1'b1 && rb[0] === 1'b1, "overtemp");
    hot = 1'b0;
    cyc(6);
    chk(reg_en === 1'b1 && ot_st === 1'b0, "cooled");
    $display("end protection");
    addr = 1'b1;
    reset_n = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    cyc(8);
    chk(bus_addr === 7'h09, "address high");
    $display("end address");
    final_report();
  end
endmodule : lnb_supply_tone_control_tb

`default_nettype wire

// [osc_divider.sv]
// Internal oscillator: converter clock and tone phase from one divider chain
`timescale 1ns/10ps
`default_nettype none
`include "lnb_defines.svh"

module osc_divider #(
  parameter int TICK_DIV  = `TICK_DIV,
  parameter int TONE_HALF = `TONE_HALF_TICKS
) (
  input  wire logic clock,       // System clock
  input  wire logic reset_n,     // Synchronous reset, active low
  output logic      osc_period,  // Pulse once per oscillator period
  output logic      conv_phase,  // Converter clock, ten times the tone rate
  output logic      tone_phase   // Symmetric tone square wave
);

  typedef struct packed {
    logic [`TICK_CNT_W-1:0] tick_cnt;
    logic [`TONE_CNT_W-1:0] tone_cnt;
    logic                   conv;
    logic                   tone;
    logic                   period;
  } div_state_t;

  div_state_t cur_ff;
  div_state_t nxt_cur;
  logic       tick;

  initial begin
    if (TICK_DIV < 2 || TICK_DIV > (1 << `TICK_CNT_W)) $error("osc_divider: bad TICK_DIV");
    if (TONE_HALF < 1 || TONE_HALF > (1 << `TONE_CNT_W)) $error("osc_divider: bad TONE_HALF");
  end

  assign tick = (cur_ff.tick_cnt == `TICK_CNT_W'(TICK_DIV - 1));

  // --------------------------------------------------------------------------
  // Tone is derived from the converter tick, so the ratio stays exact
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.period = 1'b0;
    nxt_cur.tick_cnt = tick ? '0 : cur_ff.tick_cnt + `TICK_CNT_W'(1);
    if (tick) begin
      nxt_cur.conv   = ~cur_ff.conv;
      nxt_cur.period = cur_ff.conv;
      if (cur_ff.tone_cnt == `TONE_CNT_W'(TONE_HALF - 1)) begin
        nxt_cur.tone_cnt = '0;
        nxt_cur.tone     = ~cur_ff.tone;
      end else begin
        nxt_cur.tone_cnt = cur_ff.tone_cnt + `TONE_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign osc_period = cur_ff.period;
  assign conv_phase = cur_ff.conv;
  assign tone_phase = cur_ff.tone;

endmodule : osc_divider

`default_nettype wire

// [pin_sync.sv]
// Three-stage synchroniser for asynchronous pins with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clock,    // System clock
  input  wire logic             reset_n,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] pin_in,   // Raw asynchronous pins
  output logic      [WIDTH-1:0] pin_out   // Filtered, synchronised level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t cur_ff;
  sync_state_t nxt_cur;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  // --------------------------------------------------------------------------
  // First stage feeds only the second; level moves once stages two and three agree
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_cur    = cur_ff;
    nxt_cur.s1 = pin_in;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.s3 = cur_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (cur_ff.s2[i] == cur_ff.s3[i]) begin
        nxt_cur.level[i] = cur_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pin_out = cur_ff.level;

endmodule : pin_sync

`default_nettype wire
